//--- core/smc_defines.svh
// constant definitions for the socket mode register bank
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ****************************************
// register map and reset values
// ****************************************
`define SMC_MODE_OFFSET      16'h0000
`define SMC_MODE_RESET       8'h00
`define SMC_STATE_RESET      8'h00
`define SMC_READ_FILL        8'h00

// ****************************************
// socket_mode field positions
// ****************************************
`define SMC_BIT_OPT7         7
`define SMC_BIT_OPT6         6
`define SMC_BIT_OPT5         5
`define SMC_BIT_OPT4         4
`define SMC_PROTO_MSB        3

// ****************************************
// socket_state values after open
// ****************************************
`define SMC_STATE_TCP_READY  8'h13
`define SMC_STATE_UDP_OPEN   8'h22
`define SMC_STATE_RAW_OPEN   8'h02

// ****************************************
// timing
// ****************************************
`define SMC_CLK_PERIOD_NS    5
`define SMC_RTR_UNIT_NS      100000
`define SMC_RTR_TICK_CYCLES  (`SMC_RTR_UNIT_NS / `SMC_CLK_PERIOD_NS)

`endif

//--- core/smc_mode_decode.sv
// per-socket decode of socket_mode and acknowledgement pacing
`timescale 1ns/1ps
`default_nettype none
`include "smc_defines.svh"

module smc_mode_decode #(
    parameter int RETRY_W = 16
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [7:0]         modeValue,
    input  wire logic               tick,
    input  wire logic [RETRY_W-1:0] retryTime,
    input  wire logic               rxSegment,
    output smc_pkg::smc_proto_t     protocol,
    output smc_pkg::smc_opts_t      options,
    output logic                    ackSend
);

    typedef struct packed {
        logic               ackPending;
        logic [RETRY_W-1:0] ackLeft;
        logic               ackSend;
    } smc_dec_state_t;

    smc_dec_state_t stateQ;
    smc_dec_state_t stateD;

    // ****************************************
    // protocol and option decode
    // ****************************************
    always_comb
    begin
        unique case (modeValue[`SMC_PROTO_MSB:0])
            4'h1:    protocol = smc_pkg::SMC_TCP;
            4'h2:    protocol = smc_pkg::SMC_UDP;
            4'h4:    protocol = smc_pkg::SMC_RAW;
            default: protocol = smc_pkg::SMC_CLOSED;
        endcase
        // bits that do not apply to this protocol stay stored but unused
        options = '0;
        unique case (protocol)
            smc_pkg::SMC_TCP:
            begin
                options.immediateAck = modeValue[`SMC_BIT_OPT5];
            end
            smc_pkg::SMC_UDP:
            begin
                options.multicastOn = modeValue[`SMC_BIT_OPT7];
                options.bcastBlock  = modeValue[`SMC_BIT_OPT6];
                options.igmpV1      = modeValue[`SMC_BIT_OPT7] & modeValue[`SMC_BIT_OPT5];
                options.ucastBlock  = modeValue[`SMC_BIT_OPT7] & modeValue[`SMC_BIT_OPT4];
            end
            smc_pkg::SMC_RAW:
            begin
                options.macFilter  = modeValue[`SMC_BIT_OPT7];
                options.bcastBlock = modeValue[`SMC_BIT_OPT6];
                options.mcastBlock = modeValue[`SMC_BIT_OPT5];
                options.ipv6Block  = modeValue[`SMC_BIT_OPT4];
            end
            smc_pkg::SMC_CLOSED:
            begin
            end
        endcase
    end

    // ****************************************
    // acknowledgement pacing
    // ****************************************
    always_comb
    begin
        stateD         = stateQ;
        stateD.ackSend = 1'b0;
        if (protocol != smc_pkg::SMC_TCP)
        begin
            stateD.ackPending = 1'b0;
        end
        else if (rxSegment && options.immediateAck)
        begin
            stateD.ackSend    = 1'b1;
            stateD.ackPending = 1'b0;
        end
        else if (rxSegment)
        begin
            // a newer segment restarts the wait; one ack covers both
            stateD.ackPending = 1'b1;
            stateD.ackLeft    = retryTime;
        end
        else if (stateQ.ackPending && tick)
        begin
            if (stateQ.ackLeft <= RETRY_W'(1))
            begin
                stateD.ackSend    = 1'b1;
                stateD.ackPending = 1'b0;
            end
            else
            begin
                stateD.ackLeft = stateQ.ackLeft - RETRY_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stateQ <= '0;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    assign ackSend = stateQ.ackSend;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence segImmediate;
        rxSegment && protocol == smc_pkg::SMC_TCP && modeValue[`SMC_BIT_OPT5];
    endsequence

    sequence segDelayed;
        rxSegment && protocol == smc_pkg::SMC_TCP && !modeValue[`SMC_BIT_OPT5]
            && retryTime > RETRY_W'(1) && !stateQ.ackPending;
    endsequence

    chk_ack_immediate: assert property (segImmediate |=> ackSend)
        else $error("immediate ack missing");
    chk_ack_delayed: assert property (segDelayed |=> !ackSend [*2])
        else $error("delayed ack sent too early");
    chk_igmp_gating: assert property (options.igmpV1 |-> protocol == smc_pkg::SMC_UDP
        && modeValue[`SMC_BIT_OPT7])
        else $error("igmp version select outside udp multicast");
    chk_ack_only_tcp: assert property (ackSend |-> $past(protocol) == smc_pkg::SMC_TCP)
        else $error("ack produced outside tcp mode");

endmodule : smc_mode_decode

`default_nettype wire

//--- core/smc_pkg.sv
// types shared by the socket mode register bank
package smc_pkg;

    // ****************************************
    // protocol field codes
    // ****************************************
    typedef enum logic [3:0] {
        SMC_CLOSED = 4'h0,
        SMC_TCP    = 4'h1,
        SMC_UDP    = 4'h2,
        SMC_RAW    = 4'h4
    } smc_proto_t;

    // options already gated by the selected protocol
    typedef struct packed {
        logic multicastOn;
        logic igmpV1;
        logic macFilter;
        logic bcastBlock;
        logic mcastBlock;
        logic ucastBlock;
        logic ipv6Block;
        logic immediateAck;
    } smc_opts_t;

    // decoded serial-frame register access
    typedef struct packed {
        logic        access;
        logic        write;
        logic [15:0] offset;
        logic [2:0]  socketIdx;
        logic [7:0]  wrData;
    } smc_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] socketIdx;
    } smc_sock_evt_t;

    // one received frame, classified by the mac front end
    typedef struct packed {
        logic       valid;
        logic [2:0] socketIdx;
        logic       isBroadcast;
        logic       isMulticast;
        logic       toOwnMac;
        logic       isIpv6;
    } smc_rx_frame_t;

endpackage : smc_pkg

//--- core/smc_socket_mode.sv
// socket mode register bank for eight sockets with open and receive decisions
`timescale 1ns/1ps
`default_nettype none
`include "smc_defines.svh"

module smc_socket_mode #(
    parameter int SOCKETS         = 8,
    parameter int RETRY_W         = 16,
    parameter int RTR_TICK_CYCLES = `SMC_RTR_TICK_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire smc_pkg::smc_reg_req_t         regReq,
    output logic [7:0]                         regRdData,
    output logic                               regRdValid,
    input  wire smc_pkg::smc_sock_evt_t        openReq,
    output logic [SOCKETS-1:0][7:0]            socketState,
    output smc_pkg::smc_proto_t [SOCKETS-1:0]  socketProto,
    output smc_pkg::smc_opts_t [SOCKETS-1:0]   socketOpts,
    input  wire smc_pkg::smc_rx_frame_t        rxFrame,
    output logic                               rxDone,
    output logic                               rxDrop,
    input  wire smc_pkg::smc_sock_evt_t        rxSegment,
    input  wire logic [RETRY_W-1:0]            retryTime,
    output logic [SOCKETS-1:0]                 ackSend
);

    localparam int TICK_W = (RTR_TICK_CYCLES > 1) ? $clog2(RTR_TICK_CYCLES) : 1;

    typedef struct packed {
        logic [SOCKETS-1:0][7:0] modeReg;
        logic [SOCKETS-1:0][7:0] sockState;
        logic [7:0]              rdData;
        logic                    rdValid;
        logic [TICK_W-1:0]       tickCnt;
        logic                    tick;
        logic                    rxDone;
        logic                    rxDrop;
    } smc_top_state_t;

    smc_top_state_t     stateQ;
    smc_top_state_t     stateD;
    smc_pkg::smc_opts_t rxOpts;
    smc_pkg::smc_proto_t rxProto;
    logic               rxUnicast;
    logic               dropNow;
    logic               modeHit;

    // ****************************************
    // per-socket decode and ack pacing
    // ****************************************
    for (genvar s = 0; s < SOCKETS; s++)
    begin : g_sock
        smc_mode_decode #(
            .RETRY_W (RETRY_W)
        ) i_smc_mode_decode (
            .clk       (clk),
            .rst       (rst),
            .modeValue (stateQ.modeReg[s]),
            .tick      (stateQ.tick),
            .retryTime (retryTime),
            .rxSegment (rxSegment.valid && rxSegment.socketIdx == 3'(s)),
            .protocol  (socketProto[s]),
            .options   (socketOpts[s]),
            .ackSend   (ackSend[s])
        );
    end

    // ****************************************
    // receive filter
    // ****************************************
    always_comb
    begin
        rxOpts    = socketOpts[rxFrame.socketIdx];
        rxProto   = socketProto[rxFrame.socketIdx];
        rxUnicast = !rxFrame.isBroadcast && !rxFrame.isMulticast;
        // options arrive pre-gated by protocol, so each term is one and
        dropNow   = (rxProto == smc_pkg::SMC_CLOSED)
                  | (rxFrame.isBroadcast & rxOpts.bcastBlock)
                  | (rxOpts.macFilter & !rxFrame.isBroadcast & !rxFrame.toOwnMac)
                  | (rxFrame.isMulticast & rxOpts.mcastBlock)
                  | (rxUnicast & rxOpts.ucastBlock)
                  | (rxFrame.isIpv6 & rxOpts.ipv6Block);
    end

    // ****************************************
    // register access, open, tick
    // ****************************************
    assign modeHit = regReq.access && regReq.offset == `SMC_MODE_OFFSET;

    always_comb
    begin
        stateD         = stateQ;
        stateD.rdValid = 1'b0;
        stateD.rxDone  = 1'b0;
        stateD.rxDrop  = 1'b0;
        stateD.tick    = 1'b0;
        // shared retry_time base, one tick per 100 us
        if (stateQ.tickCnt == TICK_W'(RTR_TICK_CYCLES - 1))
        begin
            stateD.tickCnt = '0;
            stateD.tick    = 1'b1;
        end
        else
        begin
            stateD.tickCnt = stateQ.tickCnt + TICK_W'(1);
        end
        if (modeHit && regReq.write)
        begin
            stateD.modeReg[regReq.socketIdx] = regReq.wrData;
        end
        if (regReq.access && !regReq.write)
        begin
            stateD.rdValid = 1'b1;
            stateD.rdData  = modeHit ? stateQ.modeReg[regReq.socketIdx] : `SMC_READ_FILL;
        end
        if (openReq.valid)
        begin
            // open on a closed socket leaves the state alone
            unique case (socketProto[openReq.socketIdx])
                smc_pkg::SMC_TCP:    stateD.sockState[openReq.socketIdx] = `SMC_STATE_TCP_READY;
                smc_pkg::SMC_UDP:    stateD.sockState[openReq.socketIdx] = `SMC_STATE_UDP_OPEN;
                smc_pkg::SMC_RAW:    stateD.sockState[openReq.socketIdx] = `SMC_STATE_RAW_OPEN;
                smc_pkg::SMC_CLOSED: stateD.sockState[openReq.socketIdx] = stateQ.sockState[openReq.socketIdx];
            endcase
        end
        if (rxFrame.valid)
        begin
            stateD.rxDone = 1'b1;
            stateD.rxDrop = dropNow;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stateQ           <= '0;
            stateQ.modeReg   <= {SOCKETS{`SMC_MODE_RESET}};
            stateQ.sockState <= {SOCKETS{`SMC_STATE_RESET}};
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    assign regRdData   = stateQ.rdData;
    assign regRdValid  = stateQ.rdValid;
    assign socketState = stateQ.sockState;
    assign rxDone      = stateQ.rxDone;
    assign rxDrop      = stateQ.rxDrop;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence modeWrite;
        regReq.access && regReq.write && regReq.offset == `SMC_MODE_OFFSET;
    endsequence

    sequence modeRead;
        regReq.access && !regReq.write && regReq.offset == `SMC_MODE_OFFSET;
    endsequence

    chk_mode_reset_clear: assert property ($past(rst) |-> stateQ.modeReg == '0)
        else $error("mode registers not cleared by reset");
    chk_mode_write_read: assert property (modeWrite ##1 (modeRead
        && regReq.socketIdx == $past(regReq.socketIdx)) |=>
        regRdValid && regRdData == $past(regReq.wrData, 2))
        else $error("mode register readback mismatch");
    chk_open_tcp_state: assert property (openReq.valid
        && socketProto[openReq.socketIdx] == smc_pkg::SMC_TCP
        |=> socketState[$past(openReq.socketIdx)] == `SMC_STATE_TCP_READY)
        else $error("tcp open state wrong");
    chk_open_udp_state: assert property (openReq.valid
        && socketProto[openReq.socketIdx] == smc_pkg::SMC_UDP
        |=> socketState[$past(openReq.socketIdx)] == `SMC_STATE_UDP_OPEN)
        else $error("udp open state wrong");
    chk_open_raw_state: assert property (openReq.valid
        && socketProto[openReq.socketIdx] == smc_pkg::SMC_RAW
        |=> socketState[$past(openReq.socketIdx)] == `SMC_STATE_RAW_OPEN)
        else $error("raw open state wrong");
    chk_bcast_block: assert property (rxFrame.valid && rxFrame.isBroadcast
        && (rxProto == smc_pkg::SMC_UDP || rxProto == smc_pkg::SMC_RAW)
        && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT6] |=> rxDone && rxDrop)
        else $error("broadcast not blocked");
    chk_raw_mac_filter: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_RAW
        && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT7]
        && !rxFrame.isBroadcast && !rxFrame.toOwnMac |=> rxDrop)
        else $error("raw mac filter let a foreign frame pass");
    chk_raw_open_pass: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_RAW
        && stateQ.modeReg[rxFrame.socketIdx][7:4] == 4'h0 |=> rxDone && !rxDrop)
        else $error("unfiltered raw frame dropped");
    chk_raw_mcast_block: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_RAW
        && rxFrame.isMulticast && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT5] |=> rxDrop)
        else $error("raw multicast not blocked");
    chk_ucast_block: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_UDP
        && rxUnicast && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT7]
        && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT4] |=> rxDrop)
        else $error("udp unicast not blocked");
    chk_raw_ipv6_block: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_RAW
        && rxFrame.isIpv6 && stateQ.modeReg[rxFrame.socketIdx][`SMC_BIT_OPT4] |=> rxDrop)
        else $error("raw ipv6 not blocked");
    chk_tcp_no_filter: assert property (rxFrame.valid && rxProto == smc_pkg::SMC_TCP
        |=> rxDone && !rxDrop)
        else $error("tcp frame dropped by foreign option");
    chk_udp_mcast_flag: assert property (socketProto[0] == smc_pkg::SMC_UDP
        |-> socketOpts[0].multicastOn == stateQ.modeReg[0][`SMC_BIT_OPT7])
        else $error("multicast enable not reflected");

endmodule : smc_socket_mode

`default_nettype wire

//--- tb/smc_host_model.sv
// host-side model issuing socket register accesses and open commands
`timescale 1ns/1ps
`default_nettype none

module smc_host_model (
    input  wire logic              clk,
    output smc_pkg::smc_reg_req_t  regReq,
    output smc_pkg::smc_sock_evt_t openReq
);
    initial
    begin
        regReq  = '0;
        openReq = '0;
    end

    // idle fields flip so a stale request never looks valid
    task automatic access(input logic wr, input logic [15:0] off, input logic [2:0] idx, input logic [7:0] val);
        @(negedge clk);
        regReq = '{access: 1'b1, write: wr, offset: off, socketIdx: idx, wrData: val};
        @(negedge clk);
        regReq = '{access: 1'b0, write: ~wr, offset: ~off, socketIdx: ~idx, wrData: ~val};
    endtask : access

    // write then read of one socket on consecutive edges
    task automatic write_read(input logic [2:0] idx, input logic [7:0] val);
        @(negedge clk);
        regReq = '{access: 1'b1, write: 1'b1, offset: 16'h0000, socketIdx: idx, wrData: val};
        @(negedge clk);
        regReq = '{access: 1'b1, write: 1'b0, offset: 16'h0000, socketIdx: idx, wrData: ~val};
        @(negedge clk);
        regReq = '{access: 1'b0, write: 1'b1, offset: 16'hFFFF, socketIdx: ~idx, wrData: val};
    endtask : write_read

    // group address and port load ahead of a multicast open lives outside this boundary
    // raw sockets open with whatever filter the caller chose; filter-on is advisory only
    task automatic open_socket(input logic [2:0] idx);
        @(negedge clk);
        openReq = '{valid: 1'b1, socketIdx: idx};
        @(negedge clk);
        openReq = '{valid: 1'b0, socketIdx: ~idx};
    endtask : open_socket
endmodule : smc_host_model

`default_nettype wire

//--- tb/smc_socket_mode_tb_top.sv
// self-checking bench for the socket mode register bank
`timescale 1ns/1ps
`default_nettype none

module smc_socket_mode_tb_top;
    localparam int TICK = 4;
    localparam logic [3:0] PROTO_TAB [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h3, 4'h8};
    logic                      clk;
    logic                      rst;
    smc_pkg::smc_reg_req_t     regReq;
    logic [7:0]                regRdData;
    logic                      regRdValid;
    smc_pkg::smc_sock_evt_t    openReq;
    logic [7:0][7:0]           socketState;
    smc_pkg::smc_proto_t [7:0] socketProto;
    smc_pkg::smc_opts_t [7:0]  socketOpts;
    smc_pkg::smc_rx_frame_t    rxFrame;
    logic                      rxDone;
    logic                      rxDrop;
    smc_pkg::smc_sock_evt_t    rxSegment;
    logic [15:0]               retryTime;
    logic [7:0]                ackSend;
    logic [7:0]                modeM [8];
    logic [7:0]                stateM [8];
    logic [7:0]                expRd [$];
    logic                      expRx [$];
    logic [7:0]                expAck [$];
    int                        nErrors;
    int                        nChecks;
    int                        seed;

    smc_host_model i_smc_host_model (.clk(clk), .regReq(regReq), .openReq(openReq));

    smc_socket_mode #(.SOCKETS(8), .RETRY_W(16), .RTR_TICK_CYCLES(TICK)) i_smc_socket_mode (
        .clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
        .openReq(openReq), .socketState(socketState), .socketProto(socketProto), .socketOpts(socketOpts),
        .rxFrame(rxFrame), .rxDone(rxDone), .rxDrop(rxDrop), .rxSegment(rxSegment),
        .retryTime(retryTime), .ackSend(ackSend));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************
    // expected values
    // ****************************************
    function automatic logic [7:0] expOpts(input logic [7:0] m);
        logic u;
        logic r;
        logic t;
        u = (m[3:0] == 4'h2);
        r = (m[3:0] == 4'h4);
        t = (m[3:0] == 4'h1);
        return {u & m[7], u & m[7] & m[5], r & m[7], (u | r) & m[6], r & m[5], u & m[7] & m[4], r & m[4], t & m[5]};
    endfunction : expOpts

    // f: broadcast, multicast, own address, ipv6
    function automatic logic expDrop(input logic [7:0] m, input logic [3:0] f);
        case (m[3:0])
            4'h1: return 1'b0;
            4'h2: return (m[6] & f[3]) | (m[7] & m[4] & ~f[3] & ~f[2]);
            4'h4: return (m[6] & f[3]) | (m[7] & ~f[3] & ~f[1]) | (m[5] & f[2]) | (m[4] & f[0]);
            default: return 1'b1;
        endcase
    endfunction : expDrop

    // ****************************************
    // compare, verdict and drivers
    // ****************************************
    task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] s);
        nChecks++;
        if (s !== e)
        begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", name, e, s);
        end
    endtask : cmp8

    task automatic results;
        if (nErrors == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic wrReg(input logic [2:0] s, input logic [15:0] off, input logic [7:0] v);
        i_smc_host_model.access(1'b1, off, s, v);
        if (off == 16'h0000)
            modeM[s] = v;
    endtask : wrReg

    task automatic rdReg(input logic [2:0] s, input logic [15:0] off, input logic [7:0] e);
        expRd.push_back(e);
        i_smc_host_model.access(1'b0, off, s, 8'h00);
    endtask : rdReg

    task automatic rxSend(input logic [2:0] s, input logic [3:0] f);
        @(negedge clk);
        rxFrame = '{valid: 1'b1, socketIdx: s, isBroadcast: f[3], isMulticast: f[2], toOwnMac: f[1], isIpv6: f[0]};
        expRx.push_back(expDrop(modeM[s], f));
        @(negedge clk);
        rxFrame.valid = 1'b0;
    endtask : rxSend

    // lo/hi bound the ack latency in cycles; hi of 0 means no ack may come
    task automatic segSend(input logic [2:0] s, input int lo, input int hi);
        int n;
        @(negedge clk);
        rxSegment = '{valid: 1'b1, socketIdx: s};
        if (hi > 0)
            expAck.push_back(8'h01 << s);
        n = 0;
        do
        begin
            @(negedge clk);
            rxSegment.valid = 1'b0;
            n++;
        end
        while (ackSend[s] !== 1'b1 && n < 40);
        cmp8("ackLatency", 8'h01, {7'h0, (hi > 0) ? (n >= lo && n <= hi) : (n == 40)});
    endtask : segSend

    // ****************************************
    // result monitor
    // ****************************************
    always @(negedge clk)
    begin
        if (!rst && regRdValid !== 1'b0)
            cmp8("regRdData", (expRd.size() > 0) ? expRd.pop_front() : ~regRdData, regRdData);
        if (!rst && rxDone !== 1'b0)
            cmp8("rxDrop", {7'h0, (expRx.size() > 0) ? expRx.pop_front() : ~rxDrop}, {7'h0, rxDrop});
        else if (!rst)
            cmp8("rxDropIdle", 8'h00, {7'h0, rxDrop});
        if (!rst && ackSend !== 8'h00)
            cmp8("ackSend", (expAck.size() > 0) ? expAck.pop_front() : 8'h00, ackSend);
    end

    // whole run is about six hundred cycles; this limit leaves ample margin
    initial
    begin
        repeat (20000) @(posedge clk);
        nErrors++;
        results();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [2:0] s;
        logic [2:0] t;
        logic [7:0] m;
        seed = $urandom(32'h9dd7);
        rst = 1'b1;
        rxFrame = '0;
        rxSegment = '0;
        retryTime = 16'h0000;
        nErrors = 0;
        nChecks = 0;
        for (int k = 0; k < 8; k++)
        begin
            modeM[k] = 8'h00;
            stateM[k] = 8'h00;
        end
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            rdReg(3'(k), 16'h0000, 8'h00);
            cmp8("socketState", 8'h00, socketState[k]);
        end
        for (int i = 0; i < 48; i++)
        begin
            s = 3'($urandom_range(7));
            m = {4'($urandom), PROTO_TAB[i % 6]};
            wrReg(s, 16'h0000, m);
            cmp8("socketProto", (m[3:0] inside {4'h1, 4'h2, 4'h4}) ? {4'h0, m[3:0]} : 8'h00, {4'h0, socketProto[s]});
            cmp8("socketOpts", expOpts(m), socketOpts[s]);
            t = 3'($urandom_range(7));
            rdReg(t, 16'h0000, modeM[t]);
            rxSend(s, 4'($urandom));
            rxSend(t, 4'($urandom));
            i_smc_host_model.open_socket(s);
            case (m[3:0])
                4'h1: stateM[s] = 8'h13;
                4'h2: stateM[s] = 8'h22;
                4'h4: stateM[s] = 8'h02;
                default: stateM[s] = stateM[s];
            endcase
            for (int k = 0; k < 8; k++)
                cmp8("socketState", stateM[k], socketState[k]);
        end
        // unmapped offset: write ignored, read gives zero
        wrReg(3'd2, 16'h0001, 8'hA5);
        rdReg(3'd2, 16'h0001, 8'h00);
        rdReg(3'd2, 16'h0000, modeM[2]);
        // back-to-back write and read: the read must already see the new value
        modeM[3] = 8'h5A;
        expRd.push_back(8'h5A);
        i_smc_host_model.write_read(3'd3, 8'h5A);
        retryTime = 16'h0003;
        wrReg(3'd5, 16'h0000, 8'h21);
        segSend(3'd5, 1, 1);
        wrReg(3'd5, 16'h0000, 8'h01);
        segSend(3'd5, 2 * TICK + 1, 3 * TICK + 1);
        wrReg(3'd6, 16'h0000, 8'h22);
        segSend(3'd6, 0, 0);
        // leaving tcp mode cancels the pending ack; the monitor catches a stray one
        wrReg(3'd5, 16'h0000, 8'h01);
        @(negedge clk);
        rxSegment = '{valid: 1'b1, socketIdx: 3'd5};
        @(negedge clk);
        rxSegment.valid = 1'b0;
        wrReg(3'd5, 16'h0000, 8'h02);
        repeat (4 * TICK + 4) @(negedge clk);
        cmp8("leftover", 8'h00, 8'(expRd.size() + expRx.size() + expAck.size()));
        results();
    end
endmodule : smc_socket_mode_tb_top

`default_nettype wire
